// file: pkg/rcb_pkg.sv
// constants and types for the repeater cascade bus arbitration block
//
// How it works
// - a chip pulls the other-port collision line when a non-holder port collides
// - every chip watches the other-port collision line, its own drive included
// - only the source or last-collision holder pulls the source collision line
// - only the source chip drives the cascade data, enable and clock lines
// - the source chip puts decoded NRZ source-port data on cascade data
// - cascade enable frames the bits that carry valid received activity
// - cascade clock goes with data and enable; receivers sample on it
// - ports form a priority chain, port 1 highest, port 7 lowest
// - chain input feeds port 1; chain output leaves after port 7
// - while idle, source port is the highest port with receive or collision
// - leaving transmit collision, last-collision port is highest still colliding
// - parallel mode: receive activity while idle pulls the chain output low
// - the same request and answer repeats during transmit collision
// - arbitration uses only chain input, chain output and source activity
// - the holder chip pulls source activity while its held port is active
// - a holder shows chain output low while chain input is high; in transmit collision the code lowers it only for a colliding port
// - other-port collision held at least 96 bit times after transmit collision
package rcb_pkg;
    // ****************************************
    // sizes and timing
    // ****************************************
    localparam int NUM_PORTS     = 7;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS   = 100;
    localparam int HOLD_BITS     = 96;
    // least time: round up to whole clock cycles
    localparam int HOLD_CYC =
        (HOLD_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W                = $clog2(HOLD_CYC + 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);
    localparam int LINK_DIV              = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int DIV_W                 = $clog2(LINK_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_RISE = DIV_W'(LINK_DIV / 2);
    localparam int FIFO_WIDTH            = 1;
    localparam int FIFO_DEPTH            = 32;
    // ****************************************
    // repeater phase as seen by arbitration
    // ****************************************
    typedef enum logic [1:0] {
        RCB_IDLE   = 2'h0,
        RCB_REPEAT = 2'h1,
        RCB_TXCOL  = 2'h3
    } rcb_phase_t;
endpackage

// file: pkg/rcb_stream_if.sv
// valid/ready stream carrier between the arbiter and its fifo
`timescale 1ns/1ps
interface rcb_stream_if #(parameter int W = 1) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport prod (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// file: core/rcb_fifo.sv
// fifo with registered read data for the cascade data path
`timescale 1ns/1ps
module rcb_fifo #(
    parameter int W     = 1,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic    core_clk,
    input wire logic    rst_n,
    // fill and drain sides
    rcb_stream_if.sink  wr,
    rcb_stream_if.prod  rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wptr;
    logic [AW:0]  rptr;
    logic         room;
    logic         out_vld;
    logic [W-1:0] out_dat;

    // ****************************************
    // pointers and flags
    // ****************************************
    wire         push      = wr.valid & room;
    wire         mem_empty = (wptr == rptr);
    // output register refills whenever memory holds data and it is empty or being taken
    wire         load      = ~mem_empty & (~out_vld | rd.ready);
    wire [AW:0]  next_wptr = wptr + (AW+1)'(push);
    wire [AW:0]  next_rptr = rptr + (AW+1)'(load);
    wire [AW:0]  next_used = next_wptr - next_rptr;

    assign wr.ready = room;
    assign rd.valid = out_vld;
    assign rd.data  = out_dat;

    // pointer registers; room is registered so the source sees a clean flop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr <= '0;
            rptr <= '0;
            room <= 1'b0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            room <= (next_used != (AW+1)'(DEPTH));
        end
    end

    // storage needs no reset
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wptr[AW-1:0]] <= wr.data;
        end
    end

    // read register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_vld <= 1'b0;
            out_dat <= '0;
        end else if (load) begin
            out_vld <= 1'b1;
            out_dat <= mem[rptr[AW-1:0]];
        end else if (rd.ready) begin
            out_vld <= 1'b0;
        end
    end
endmodule

// file: core/rcb_arbiter.sv
// top of the repeater cascade bus arbitration block
`timescale 1ns/1ps
module rcb_arbiter
    import rcb_pkg::*;
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // local port activity from the transceivers
    input  wire logic [NUM_PORTS-1:0] port_rx_act,
    input  wire logic [NUM_PORTS-1:0] port_col_act,
    // repeater state from the main state machine
    input  wire logic                 rpt_idle,
    input  wire logic                 rpt_tx_col,
    // decoded source-port data from the decoder
    input  wire logic                 dec_data,
    input  wire logic                 dec_valid,
    output logic                      dec_ready,
    // arbitration chain
    input  wire logic                 arb_chain_in_n,
    output logic                      arb_chain_out_n,
    // shared open-drain lines
    input  wire logic                 other_port_collision_n_in,
    output logic                      other_port_collision_n_o,
    output logic                      other_port_collision_n_oe,
    input  wire logic                 source_port_collision_n_in,
    output logic                      source_port_collision_n_o,
    output logic                      source_port_collision_n_oe,
    input  wire logic                 source_activity_n_in,
    output logic                      source_activity_n_o,
    output logic                      source_activity_n_oe,
    // cascade receive lines, driven by the source chip only
    input  wire logic                 cascade_rx_data_in,
    output logic                      cascade_rx_data_o,
    output logic                      cascade_rx_data_oe,
    input  wire logic                 cascade_rx_enable_in,
    output logic                      cascade_rx_enable_o,
    output logic                      cascade_rx_enable_oe,
    input  wire logic                 cascade_rx_clock_in,
    output logic                      cascade_rx_clock_o,
    output logic                      cascade_rx_clock_oe,
    // results toward the main state machine
    output logic [NUM_PORTS-1:0]      source_port,
    output logic [NUM_PORTS-1:0]      last_collision_port,
    output logic                      chip_is_holder,
    output logic                      other_col_seen,
    output logic                      jam_request,
    output logic                      rx_bit,
    output logic                      rx_bit_valid,
    output logic                      rx_frame
);
    localparam int SYNC_W = 2 * NUM_PORTS + 7;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [SYNC_W-1:0] sync_q1;
    logic [SYNC_W-1:0] sync_q2;
    logic              clk_seen;
    // active-low open-drain lines are inverted ahead of the flops so reset reads idle; arb_chain_in_n goes in as is
    wire  [SYNC_W-1:0] sync_d = {port_rx_act, port_col_act, arb_chain_in_n,
                                 ~other_port_collision_n_in,
                                 ~source_port_collision_n_in,
                                 ~source_activity_n_in, cascade_rx_data_in,
                                 cascade_rx_enable_in, cascade_rx_clock_in};
    wire  [NUM_PORTS-1:0] rx_s  = sync_q2[SYNC_W-1 -: NUM_PORTS];
    wire  [NUM_PORTS-1:0] col_s = sync_q2[NUM_PORTS+6:7];
    wire  ack_ok     = sync_q2[6];
    wire  opc_s      = sync_q2[5];
    wire  spc_s      = sync_q2[4];
    wire  sact_s     = sync_q2[3];
    wire  crd_s      = sync_q2[2];
    wire  cre_s      = sync_q2[1];
    wire  crc_s      = sync_q2[0];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q1  <= '0;
            sync_q2  <= '0;
            clk_seen <= 1'b0;
        end else begin
            sync_q1  <= sync_d;
            sync_q2  <= sync_q1;
            clk_seen <= crc_s;
        end
    end

    // ****************************************
    // repeater phase tracking
    // ****************************************
    rcb_phase_t phase;
    rcb_phase_t next_phase;

    always_comb begin
        case (phase)
            RCB_IDLE:   next_phase = rpt_idle ? RCB_IDLE : RCB_REPEAT;
            RCB_REPEAT: next_phase = rpt_tx_col ? RCB_TXCOL :
                                     (rpt_idle ? RCB_IDLE : RCB_REPEAT);
            RCB_TXCOL:  next_phase = rpt_tx_col ? RCB_TXCOL :
                                     (rpt_idle ? RCB_IDLE : RCB_REPEAT);
            default:    next_phase = RCB_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= RCB_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // ****************************************
    // priority chain
    // ****************************************
    wire                  in_idle  = (phase == RCB_IDLE);
    wire                  in_txcol = (phase == RCB_TXCOL);
    wire [NUM_PORTS-1:0]  own      = source_port | last_collision_port;
    // outside arbitration the held ports keep the grant so the chain stays low
    wire [NUM_PORTS-1:0]  req      = in_idle ? (rx_s | col_s) :
                                     (in_txcol ? col_s : own);
    wire [NUM_PORTS:0]    grant;
    wire [NUM_PORTS-1:0]  win      = grant[NUM_PORTS-1:0] & req;

    assign grant[0] = ack_ok;
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_chain
        // index 0 is port 1, the highest priority
        assign grant[i+1] = grant[i] & ~req[i];
    end

    // selection registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            source_port         <= '0;
            last_collision_port <= '0;
        end else begin
            if (in_idle) begin
                source_port <= win;
            end
            if (in_idle) begin
                last_collision_port <= '0;
            end else if (in_txcol) begin
                last_collision_port <= win;
            end
        end
    end

    // ****************************************
    // shared line drive
    // ****************************************
    logic [HOLD_W-1:0] hold_cnt;
    wire  hold_on   = (hold_cnt != '0);
    wire  txcol_in  = (phase != RCB_TXCOL) && (next_phase == RCB_TXCOL);
    wire  other_col = |(col_s & ~own);
    wire  own_col   = |(col_s & own);
    wire  own_act   = |((rx_s | col_s) & own);

    // jam is forced for the minimum time after transmit collision starts
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt <= '0;
        end else if (txcol_in) begin
            hold_cnt <= HOLD_LOAD;
        end else if (hold_on) begin
            hold_cnt <= hold_cnt - HOLD_W'(1);
        end
    end

    // open drain: the level is always low, only the enables move
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            other_port_collision_n_oe  <= 1'b0;
            source_port_collision_n_oe <= 1'b0;
            source_activity_n_oe       <= 1'b0;
            arb_chain_out_n            <= 1'b1;
            chip_is_holder             <= 1'b0;
        end else begin
            other_port_collision_n_oe  <= other_col | hold_on;
            source_port_collision_n_oe <= own_col;
            source_activity_n_oe       <= own_act;
            arb_chain_out_n            <= grant[NUM_PORTS];
            chip_is_holder             <= |own;
        end
    end

    // monitor the wired lines, own drive included
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            other_col_seen <= 1'b0;
            jam_request    <= 1'b0;
        end else begin
            other_col_seen <= opc_s;
            jam_request    <= opc_s | spc_s | (sact_s & 1'b0);
        end
    end

    // ****************************************
    // cascade transmit path
    // ****************************************
    rcb_stream_if #(.W(FIFO_WIDTH)) fill_if ();
    rcb_stream_if #(.W(FIFO_WIDTH)) drain_if ();
    logic [DIV_W-1:0] div_cnt;
    logic             od_level;
    logic             data_oe;
    wire  is_src   = (|source_port) & ~in_idle;
    wire  bit_tick = (div_cnt == DIV_LAST);

    assign fill_if.valid  = dec_valid;
    assign fill_if.data   = dec_data;
    assign dec_ready      = fill_if.ready;
    // stale bits are flushed while this chip is not the source
    assign drain_if.ready = bit_tick | ~is_src;

    rcb_fifo #(.W(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr       (fill_if.sink),
        .rd       (drain_if.prod)
    );

    // bit divider: clock low at bit start, high half way for receivers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= bit_tick ? '0 : div_cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cascade_rx_data_o   <= 1'b0;
            cascade_rx_enable_o <= 1'b0;
            cascade_rx_clock_o  <= 1'b0;
            data_oe             <= 1'b0;
            od_level            <= 1'b0;
        end else begin
            data_oe <= is_src;
            if (bit_tick) begin
                cascade_rx_data_o   <= drain_if.data & is_src;
                cascade_rx_enable_o <= drain_if.valid & is_src;
                cascade_rx_clock_o  <= 1'b0;
            end else begin
                cascade_rx_enable_o <= cascade_rx_enable_o & is_src;
                if (div_cnt == DIV_RISE) begin
                    cascade_rx_clock_o <= 1'b1;
                end
            end
        end
    end

    assign cascade_rx_data_oe         = data_oe;
    assign cascade_rx_enable_oe       = data_oe;
    assign cascade_rx_clock_oe        = data_oe;
    assign other_port_collision_n_o   = od_level;
    assign source_port_collision_n_o  = od_level;
    assign source_activity_n_o        = od_level;

    // ****************************************
    // cascade receive path
    // ****************************************
    wire crc_rise = crc_s & ~clk_seen;

    // other chips sample data and enable on the cascade clock rising edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_bit       <= 1'b0;
            rx_bit_valid <= 1'b0;
            rx_frame     <= 1'b0;
        end else begin
            rx_frame     <= cre_s;
            rx_bit_valid <= crc_rise & ~is_src & cre_s;
            if (crc_rise) begin
                rx_bit <= crd_s;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_other_col;
        other_col |=> other_port_collision_n_oe;
    endproperty
    a_other_col: assert property (p_other_col)
        else $error("other-port collision not driven");

    property p_hold;
        txcol_in |=> (hold_cnt == HOLD_LOAD) ##1 other_port_collision_n_oe[*8];
    endproperty
    a_hold: assert property (p_hold)
        else $error("collision hold not started");

    property p_src_col;
        !own_col |=> !source_port_collision_n_oe;
    endproperty
    a_src_col: assert property (p_src_col)
        else $error("source collision driven by non holder");

    property p_rx_drive;
        !is_src |=> !cascade_rx_data_oe && !cascade_rx_clock_oe;
    endproperty
    a_rx_drive: assert property (p_rx_drive)
        else $error("cascade lines driven by non source");

    property p_chain;
        (ack_ok && req != '0) |-> win == (req & (~req + NUM_PORTS'(1)));
    endproperty
    a_chain: assert property (p_chain)
        else $error("chain winner is not highest port");

    property p_chain_io;
        !ack_ok |=> !arb_chain_out_n;
    endproperty
    a_chain_io: assert property (p_chain_io)
        else $error("chain output high without grant in");

    property p_src_sel;
        in_idle |=> source_port == $past(win);
    endproperty
    a_src_sel: assert property (p_src_sel)
        else $error("source port not taken from chain");

    property p_lc_sel;
        in_txcol |=> last_collision_port == $past(win);
    endproperty
    a_lc_sel: assert property (p_lc_sel)
        else $error("last collision port not taken from chain");

    property p_request;
        (in_idle && rx_s != '0) |=> !arb_chain_out_n;
    endproperty
    a_request: assert property (p_request)
        else $error("idle activity did not request");

    property p_activity;
        own_act |=> source_activity_n_oe;
    endproperty
    a_activity: assert property (p_activity)
        else $error("source activity not driven");

    property p_enable;
        cascade_rx_enable_o |-> cascade_rx_enable_oe;
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable high while not driven");
endmodule

// file: verif/rcb_peer_model.sv
// far-side peer chip that sources the cascade receive lines
`timescale 1ns/1ps
module rcb_peer_model (
    // frame request from the bench
    input  wire logic        start,
    input  wire logic [15:0] bits,
    // cascade lines while this peer holds the source port
    output logic             p_clk,
    output logic             p_data,
    output logic             p_en,
    output logic             p_oe
);
    // ****
    // frame sender
    // ****
    // link clock stands still low between frames, 80 ns inside them
    initial begin
        p_clk = 1'b0;
        p_data = 1'b0;
        p_en = 1'b0;
        p_oe = 1'b0;
        forever begin
            @(posedge start);
            #3;
            p_oe = 1'b1;
            for (int i = 0; i < 16; i++) begin
                p_data = bits[i];
                p_en = 1'b1;
                #40 p_clk = 1'b1;
                #40 p_clk = 1'b0;
            end
            p_en = 1'b0;
            #40 p_oe = 1'b0;
        end
    end
endmodule

// file: verif/testbench.sv
// self-checking bench for the cascade bus arbitration block
`timescale 1ns/1ps
module testbench
    import rcb_pkg::*;
;
    // ****
    // signals and scoreboard
    // ****
    localparam int LIMIT_CYC = 6000;
    logic core_clk = 1'b0;
    logic rst_n;
    logic [NUM_PORTS-1:0] port_rx_act, port_col_act, source_port, last_collision_port;
    logic rpt_idle, rpt_tx_col, dec_data, dec_valid, dec_ready;
    logic arb_chain_in_n, arb_chain_out_n;
    logic other_port_collision_n_in, other_port_collision_n_oe;
    logic source_port_collision_n_in, source_port_collision_n_oe;
    logic source_activity_n_in, source_activity_n_oe;
    logic other_port_collision_n_o, source_port_collision_n_o, source_activity_n_o;
    logic cascade_rx_data_in, cascade_rx_data_o, cascade_rx_data_oe;
    logic cascade_rx_enable_in, cascade_rx_enable_o, cascade_rx_enable_oe;
    logic cascade_rx_clock_in, cascade_rx_clock_o, cascade_rx_clock_oe;
    logic chip_is_holder, other_col_seen, jam_request, rx_bit, rx_bit_valid, rx_frame;
    logic peer_pull, start, p_clk, p_data, p_en, p_oe;
    logic tog = 1'b0;
    logic c_prev = 1'b0;
    logic [15:0] bits;
    logic [31:0] seed = 32'h2148EE7E;
    logic q_tx[$];
    logic q_rx[$];
    int num_errors = 0;
    int checked = 0;

    always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    // open-drain lines: low while any party pulls
    // a driven line shows the level that the chip puts out, so a wrong level fails
    assign other_port_collision_n_in  = !(other_port_collision_n_oe && !other_port_collision_n_o)
                                        && !peer_pull;
    assign source_port_collision_n_in =
        !(source_port_collision_n_oe && !source_port_collision_n_o);
    assign source_activity_n_in       = !(source_activity_n_oe && !source_activity_n_o);
    // unowned data and enable show a changing pattern, not a stale bit
    assign cascade_rx_data_in   = cascade_rx_data_oe ? cascade_rx_data_o : p_oe ? p_data : tog;
    assign cascade_rx_enable_in = cascade_rx_enable_oe ? cascade_rx_enable_o : p_oe ? p_en : tog;
    assign cascade_rx_clock_in  = cascade_rx_clock_oe ? cascade_rx_clock_o : p_clk;

    rcb_arbiter rcb_arbiter_i (
        .core_clk, .rst_n, .port_rx_act, .port_col_act, .rpt_idle, .rpt_tx_col,
        .dec_data, .dec_valid, .dec_ready, .arb_chain_in_n, .arb_chain_out_n,
        .other_port_collision_n_in, .other_port_collision_n_o,
        .other_port_collision_n_oe, .source_port_collision_n_in,
        .source_port_collision_n_o, .source_port_collision_n_oe,
        .source_activity_n_in, .source_activity_n_o, .source_activity_n_oe,
        .cascade_rx_data_in, .cascade_rx_data_o, .cascade_rx_data_oe,
        .cascade_rx_enable_in, .cascade_rx_enable_o, .cascade_rx_enable_oe,
        .cascade_rx_clock_in, .cascade_rx_clock_o, .cascade_rx_clock_oe,
        .source_port, .last_collision_port, .chip_is_holder, .other_col_seen,
        .jam_request, .rx_bit, .rx_bit_valid, .rx_frame
    );
    rcb_peer_model rcb_peer_model_i (
        .start, .bits, .p_clk, .p_data, .p_en, .p_oe
    );

    // ****
    // helpers
    // ****
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic results;
        $display("mismatches %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****
    // notes and watchers
    // ****
    // accepted decoder bits become expected wire bits, in order
    always @(posedge core_clk) begin
        tog <= ~tog;
        if (dec_valid && dec_ready === 1'b1) q_tx.push_back(dec_data);
    end
    // a bit counts on the wire at a rising cascade clock inside the frame
    always @(posedge core_clk) begin
        c_prev <= cascade_rx_clock_o;
        if (cascade_rx_clock_o && !c_prev && cascade_rx_enable_o && cascade_rx_data_oe) begin
            if (q_tx.size() == 0) chk("tx_extra", 0, 1);
            else chk("tx_bit", q_tx.pop_front(), cascade_rx_data_o);
        end
        if (rx_bit_valid === 1'b1 && q_rx.size() == 0) chk("rx_extra", 0, 1);
        else if (rx_bit_valid === 1'b1) chk("rx_bit", q_rx.pop_front(), rx_bit);
    end

    // watchdog: the sequence needs under half of this span
    initial begin
        #(LIMIT_CYC * CLK_PERIOD_NS);
        num_errors++;
        results();
    end

    // ****
    // main sequence
    // ****
    initial begin
        logic [NUM_PORTS-1:0] v;
        rst_n = 1'b0;
        port_rx_act = '0;
        port_col_act = '0;
        rpt_idle = 1'b1;
        rpt_tx_col = 1'b0;
        dec_data = 1'b0;
        dec_valid = 1'b0;
        arb_chain_in_n = 1'b1;
        peer_pull = 1'b0;
        start = 1'b0;
        bits = '0;
        step(8);
        rst_n = 1'b1;
        step(2);
        // idle selection: receive or collision, lowest bit wins
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 7'h7F : (i == 1 || seed[6:0] == 0) ? 7'h40 : seed[6:0];
            port_rx_act = v & seed[13:7];
            port_col_act = v & ~seed[13:7];
            step(5);
            chk("source_port", v & (~v + 1'b1), source_port);
            chk("chain_out", 0, arb_chain_out_n);
            chk("activity_oe", 1, source_activity_n_oe);
            chk("holder", 1, chip_is_holder);
        end
        port_rx_act = '0;
        port_col_act = '0;
        step(5);
        chk("chain_pass", 1, arb_chain_out_n);
        // bench plays the outside arbiter: withhold the grant, then answer this chip
        arb_chain_in_n = 1'b0;
        step(5);
        chk("chain_absent", 0, arb_chain_out_n);
        arb_chain_in_n = 1'b1;
        // repeat with port 3 as source; collisions elsewhere and on it
        port_rx_act = 7'h04;
        step(2);
        rpt_idle = 1'b0;
        step(5);
        chk("source_kept", 7'h04, source_port);
        chk("data_oe", 1, cascade_rx_data_oe);
        chk("enable_oe", 1, cascade_rx_enable_oe);
        chk("clock_oe", 1, cascade_rx_clock_oe);
        port_col_act = 7'h10;
        // pull, two sync flops on the line, then the monitor flop
        step(7);
        chk("other_oe", 1, other_port_collision_n_oe);
        chk("other_seen", 1, other_col_seen);
        chk("jam", 1, jam_request);
        chk("src_col_oe", 0, source_port_collision_n_oe);
        port_col_act = 7'h04;
        step(5);
        chk("src_col_oe", 1, source_port_collision_n_oe);
        chk("other_oe", 0, other_port_collision_n_oe);
        port_col_act = '0;
        peer_pull = 1'b1;
        step(5);
        chk("peer_seen", 1, other_col_seen);
        peer_pull = 1'b0;
        // transmit collision: last-collision choice and the long hold
        rpt_tx_col = 1'b1;
        port_col_act = 7'h30;
        step(5);
        chk("last_col", 7'h10, last_collision_port);
        rpt_tx_col = 1'b0;
        step(1);
        port_col_act = '0;
        step(5);
        chk("last_kept", 7'h10, last_collision_port);
        step(880);
        chk("hold_on", 1, other_port_collision_n_oe);
        step(100);
        chk("hold_off", 0, other_port_collision_n_oe);
        // cascade send: fill the fifo past refusal, then drain
        rpt_idle = 1'b1;
        port_rx_act = 7'h01;
        step(3);
        rpt_idle = 1'b0;
        step(5);
        dec_valid = 1'b1;
        for (int i = 0; i < 200 && dec_ready === 1'b1; i++) begin
            seed = xs(seed);
            dec_data = seed[0];
            step(1);
        end
        chk("refused", 0, dec_ready);
        step(20);
        dec_valid = 1'b0;
        for (int i = 0; i < 1000 && q_tx.size() > 0; i++) step(1);
        chk("tx_left", 0, q_tx.size());
        step(30);
        chk("enable_idle", 0, cascade_rx_enable_o);
        // cascade receive from a peer source at its faster 80 ns link clock
        rpt_idle = 1'b1;
        port_rx_act = '0;
        step(5);
        chk("data_oe", 0, cascade_rx_data_oe);
        chk("clock_oe", 0, cascade_rx_clock_oe);
        seed = xs(seed);
        bits = seed[15:0];
        for (int i = 0; i < 16; i++) q_rx.push_back(bits[i]);
        start = 1'b1;
        step(1);
        start = 1'b0;
        step(20);
        chk("rx_frame", 1, rx_frame);
        for (int i = 0; i < 400 && q_rx.size() > 0; i++) step(1);
        chk("rx_left", 0, q_rx.size());
        results();
    end
endmodule
